// >>> twrap_bm.sv
// two-wire bus master model, open-drain drive of clock and data
`timescale 1ns/1ps
`default_nettype none
module twrap_bm (
    input  wire logic clk_sys,
    input  wire logic sda_line,
    output logic      scl_low,
    output logic      sda_low
);
    // ****************************************
    // bus idle: both lines released
    // ****************************************
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end
    task automatic q(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // start or repeated start, clock left low
    task automatic start();
        q(2);
        sda_low <= 1'b0;
        q(2);
        scl_low <= 1'b0;
        q(4);
        sda_low <= 1'b1;
        q(4);
        scl_low <= 1'b1;
    endtask
    task automatic stop();
        q(2);
        sda_low <= 1'b1;
        q(2);
        scl_low <= 1'b0;
        q(4);
        sda_low <= 1'b0;
        q(4);
    endtask
    // one bit, 80 ns clock period inside frames
    task automatic bit_io(input logic b, output logic r);
        q(2);
        sda_low <= ~b;
        q(2);
        scl_low <= 1'b0;
        q(2);
        r = sda_line;
        q(2);
        scl_low <= 1'b1;
    endtask
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask
    task automatic rd_byte(input logic ack_it, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(~ack_it, r);
    endtask
endmodule
`default_nettype wire

// >>> twrap_pkg.sv
// package: constants for the two-wire register access port
package twrap_pkg;
    localparam logic [4:0]  ADDR_UPPER      = 5'h12;
    localparam logic [7:0]  PTR_RESET       = 8'h00;
    localparam logic [7:0]  PTR_TEMP_LAST   = 8'h08;
    localparam logic [7:0]  PTR_BLOCK_FIRST = 8'h80;
    localparam logic [7:0]  PTR_BLOCK_LAST  = 8'h88;
    localparam logic [7:0]  PTR_SW_RESET    = 8'h20;
    localparam logic [7:0]  PTR_CONFIG      = 8'h30;
    localparam logic [7:0]  PTR_LIMIT_LAST  = 8'h4f;
    localparam logic [7:0]  PTR_LOCK        = 8'hc4;
    localparam int          SW_RESET_BIT    = 15;
    localparam logic [15:0] LOCK_KEY        = 16'h5ca6;
    localparam logic [15:0] UNLOCK_KEY      = 16'heb19;
    localparam logic [4:0]  HS_CODE_TOP     = 5'h01;
    localparam logic [1:0]  STRAP_GND       = 2'h0;
    localparam logic [1:0]  STRAP_VDD       = 2'h1;
    localparam logic [1:0]  STRAP_SDA       = 2'h2;
    localparam logic [1:0]  STRAP_SCL       = 2'h3;
    localparam real         CLK_MHZ         = 100.0;
    localparam real         TIMEOUT_MS      = 17.5;
    localparam int          TIMEOUT_CYCLES  = int'(TIMEOUT_MS * CLK_MHZ * 1000.0);
    localparam int          NUM_TEMP        = 9;
    typedef enum logic [2:0] {
        TWRAP_IDLE  = 3'b000,
        TWRAP_ADDR  = 3'b001,
        TWRAP_RXB   = 3'b010,
        TWRAP_TXB   = 3'b011,
        TWRAP_ACKRX = 3'b100,
        TWRAP_ACKTX = 3'b101,
        TWRAP_WAIT  = 3'b110
    } twrap_state_t;
endpackage

// >>> twrap_top.sv
// module: two-wire slave with pointer, block read, timeout, hs mode and lock
`timescale 1ns/1ps
`default_nettype none
module twrap_top #(
    parameter int TIMEOUT_LIMIT = twrap_pkg::TIMEOUT_CYCLES
) (
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe,
    input  wire logic [1:0]  addr_strap,
    input  wire logic [15:0] temp_result [twrap_pkg::NUM_TEMP],
    output logic             hs_mode,
    output logic             sw_reset_pulse,
    output logic             locked,
    output logic             reg_wr_valid,
    output logic [7:0]       reg_wr_ptr,
    output logic [15:0]      reg_wr_data
);
    // ************************************************
    // state
    // ************************************************
    typedef struct packed {
        logic [1:0]             scl_sync;
        logic [1:0]             sda_sync;
        logic [3:0]             strap_sync;
        logic                   scl_q;
        logic                   sda_q;
        twrap_pkg::twrap_state_t st;
        logic [3:0]             bitcnt;
        logic [7:0]             shreg;
        logic                   first_byte;
        logic                   rd_dir;
        logic                   ptr_phase;
        logic                   low_phase;
        logic                   nack_pend;
        logic [7:0]             ptr;
        logic [7:0]             hi_byte;
        logic [15:0]            tx_word;
        logic                   busy;
        logic [24:0]            tocnt;
        logic                   sda_out;
        logic                   sda_oe;
        logic                   hs_mode;
        logic                   sw_reset_pulse;
        logic                   locked;
        logic                   wr_valid;
        logic [7:0]             wr_ptr;
        logic [15:0]            wr_data;
    } twrap_regs_t;

    twrap_regs_t r;
    twrap_regs_t next_r;

    // ************************************************
    // helpers
    // ************************************************
    function automatic logic is_protected(input logic [7:0] p);
        is_protected = (p >= twrap_pkg::PTR_CONFIG) && (p <= twrap_pkg::PTR_LIMIT_LAST);
    endfunction

    function automatic logic [15:0] read_word(input logic [7:0] p, input logic lk,
                                              input logic [15:0] t [twrap_pkg::NUM_TEMP]);
        logic [3:0] idx;
        idx = p[3:0];
        read_word = 16'h0000;
        if ((p <= twrap_pkg::PTR_TEMP_LAST) ||
            (p >= twrap_pkg::PTR_BLOCK_FIRST && p <= twrap_pkg::PTR_BLOCK_LAST)) begin
            read_word = t[idx];
        end else if (p == twrap_pkg::PTR_LOCK) begin
            read_word = {15'h0000, lk};
        end
    endfunction

    logic [6:0] my_addr;
    always_comb begin
        my_addr = {twrap_pkg::ADDR_UPPER, r.strap_sync[3:2]};
    end

    // ************************************************
    // next state
    // ************************************************
    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;
    logic [7:0] rx_byte;
    logic [15:0] wdata;

    always_comb begin
        next_r = r;
        next_r.scl_sync = {r.scl_sync[0], scl_in};
        next_r.sda_sync = {r.sda_sync[0], sda_in};
        next_r.strap_sync = {r.strap_sync[1:0], addr_strap};
        next_r.scl_q = r.scl_sync[1];
        next_r.sda_q = r.sda_sync[1];
        next_r.sw_reset_pulse = 1'b0;
        next_r.wr_valid = 1'b0;
        scl_rise = r.scl_sync[1] && !r.scl_q;
        scl_fall = !r.scl_sync[1] && r.scl_q;
        start_c = r.scl_sync[1] && r.scl_q && r.sda_q && !r.sda_sync[1];
        stop_c = r.scl_sync[1] && r.scl_q && !r.sda_q && r.sda_sync[1];
        rx_byte = {r.shreg[6:0], r.sda_sync[1]};
        wdata = {r.hi_byte, r.shreg};

        if (r.busy && (!r.scl_sync[1] || !r.sda_sync[1])) begin
            next_r.tocnt = r.tocnt + 25'd1;
        end else begin
            next_r.tocnt = 25'd0;
        end

        if (start_c) begin
            next_r.st = twrap_pkg::TWRAP_ADDR;
            next_r.bitcnt = 4'd0;
            next_r.busy = 1'b1;
            next_r.tocnt = 25'd0;
            next_r.sda_oe = 1'b0;
            next_r.low_phase = 1'b0;
            next_r.first_byte = 1'b1;
        end else if (stop_c) begin
            next_r.st = twrap_pkg::TWRAP_IDLE;
            next_r.busy = 1'b0;
            next_r.sda_oe = 1'b0;
            next_r.hs_mode = 1'b0;
            next_r.first_byte = 1'b1;
        end else if (r.busy && r.tocnt >= 25'(TIMEOUT_LIMIT)) begin
            next_r.st = twrap_pkg::TWRAP_IDLE;
            next_r.busy = 1'b0;
            next_r.sda_oe = 1'b0;
            next_r.tocnt = 25'd0;
            next_r.first_byte = 1'b1;
        end else begin
            unique case (r.st)
                twrap_pkg::TWRAP_IDLE: begin
                end
                twrap_pkg::TWRAP_WAIT: begin
                    if (scl_fall) begin
                        next_r.sda_oe = 1'b0;
                    end
                end
                twrap_pkg::TWRAP_ADDR, twrap_pkg::TWRAP_RXB: begin
                    if (scl_fall && r.bitcnt == 4'd0) begin
                        next_r.sda_oe = 1'b0;
                    end
                    if (scl_rise) begin
                        if (r.bitcnt == 4'hf) begin
                            // ack clock of the previous byte, not data
                            next_r.bitcnt = 4'd0;
                        end else begin
                            next_r.shreg = rx_byte;
                            next_r.bitcnt = r.bitcnt + 4'd1;
                            if (r.bitcnt == 4'd7) begin
                                next_r.bitcnt = 4'd0;
                                next_r.st = twrap_pkg::TWRAP_ACKRX;
                            end
                        end
                    end
                end
                twrap_pkg::TWRAP_ACKRX: begin
                    if (scl_fall) begin
                        next_r.sda_out = 1'b0;
                        next_r.sda_oe = 1'b0;
                        next_r.bitcnt = 4'hf;
                        next_r.st = twrap_pkg::TWRAP_WAIT;
                        if (r.bitcnt == 4'd0 && r.first_byte && r.shreg[7:3] == twrap_pkg::HS_CODE_TOP) begin
                            next_r.hs_mode = 1'b1;
                            next_r.first_byte = 1'b0;
                        end else if (r.first_byte) begin
                            next_r.first_byte = 1'b0;
                            if (r.shreg[7:1] == my_addr) begin
                                next_r.sda_oe = 1'b1;
                                next_r.rd_dir = r.shreg[0];
                                next_r.ptr_phase = !r.shreg[0];
                                next_r.low_phase = 1'b0;
                                next_r.st = r.shreg[0] ? twrap_pkg::TWRAP_ACKTX : twrap_pkg::TWRAP_RXB;
                                next_r.tx_word = read_word(r.ptr, r.locked, temp_result);
                            end
                        end else if (r.ptr_phase) begin
                            next_r.ptr = r.shreg;
                            next_r.ptr_phase = 1'b0;
                            next_r.sda_oe = 1'b1;
                            next_r.st = twrap_pkg::TWRAP_RXB;
                        end else if (is_protected(r.ptr) && r.locked) begin
                            next_r.st = twrap_pkg::TWRAP_WAIT;
                        end else begin
                            next_r.sda_oe = 1'b1;
                            next_r.st = twrap_pkg::TWRAP_RXB;
                            next_r.low_phase = !r.low_phase;
                            if (!r.low_phase) begin
                                next_r.hi_byte = r.shreg;
                            end else begin
                                next_r.wr_valid = 1'b1;
                                next_r.wr_ptr = r.ptr;
                                next_r.wr_data = wdata;
                                if (r.ptr == twrap_pkg::PTR_LOCK && wdata == twrap_pkg::LOCK_KEY) begin
                                    next_r.locked = 1'b1;
                                end
                                if (r.ptr == twrap_pkg::PTR_LOCK && wdata == twrap_pkg::UNLOCK_KEY) begin
                                    next_r.locked = 1'b0;
                                end
                                if (r.ptr == twrap_pkg::PTR_SW_RESET && wdata[twrap_pkg::SW_RESET_BIT]) begin
                                    next_r.sw_reset_pulse = 1'b1;
                                    next_r.ptr = twrap_pkg::PTR_RESET;
                                end
                            end
                        end
                    end
                end
                twrap_pkg::TWRAP_ACKTX: begin
                    if (scl_fall) begin
                        next_r.sda_oe = !r.tx_word[15];
                        next_r.sda_out = 1'b0;
                        next_r.tx_word = {r.tx_word[14:0], 1'b0};
                        next_r.bitcnt = 4'd1;
                        next_r.st = twrap_pkg::TWRAP_TXB;
                    end
                end
                twrap_pkg::TWRAP_TXB: begin
                    if (scl_fall) begin
                        if (r.bitcnt == 4'd8) begin
                            next_r.sda_oe = 1'b0;
                            next_r.bitcnt = 4'd0;
                        end else begin
                            next_r.sda_oe = !r.tx_word[15];
                            next_r.tx_word = {r.tx_word[14:0], 1'b0};
                            next_r.bitcnt = r.bitcnt + 4'd1;
                        end
                    end
                    if (scl_rise && r.bitcnt == 4'd0) begin
                        if (r.low_phase && r.ptr >= twrap_pkg::PTR_BLOCK_FIRST
                            && r.ptr <= twrap_pkg::PTR_BLOCK_LAST) begin
                            next_r.ptr = (r.ptr == twrap_pkg::PTR_BLOCK_LAST) ?
                                twrap_pkg::PTR_BLOCK_FIRST : r.ptr + 8'd1;
                        end
                        if (r.sda_sync[1]) begin
                            next_r.st = twrap_pkg::TWRAP_WAIT;
                        end else begin
                            next_r.st = twrap_pkg::TWRAP_ACKTX;
                            next_r.low_phase = !r.low_phase;
                            if (r.low_phase) begin
                                next_r.tx_word = read_word(next_r.ptr, r.locked, temp_result);
                            end
                        end
                    end
                end
                default: begin
                    next_r.st = twrap_pkg::TWRAP_IDLE;
                end
            endcase
        end
    end

    // ************************************************
    // registers
    // ************************************************
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            r <= '0;
            r.scl_sync <= 2'b11;
            r.sda_sync <= 2'b11;
            r.scl_q <= 1'b1;
            r.sda_q <= 1'b1;
            r.first_byte <= 1'b1;
            r.ptr <= twrap_pkg::PTR_RESET;
            r.locked <= 1'b1;
        end else if (r.sw_reset_pulse) begin
            r <= next_r;
            r.locked <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    assign sda_out = r.sda_out;
    assign sda_oe = r.sda_oe;
    assign hs_mode = r.hs_mode;
    assign sw_reset_pulse = r.sw_reset_pulse;
    assign locked = r.locked;
    assign reg_wr_valid = r.wr_valid;
    assign reg_wr_ptr = r.wr_ptr;
    assign reg_wr_data = r.wr_data;

    // ************************************************
    // checks
    // ************************************************
    chk_lock_key: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (r.wr_valid && r.wr_ptr == twrap_pkg::PTR_LOCK && r.wr_data == twrap_pkg::LOCK_KEY) |-> r.locked)
        else $error("lock key did not lock");
    chk_unlock_key: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (r.wr_valid && r.wr_ptr == twrap_pkg::PTR_LOCK && r.wr_data == twrap_pkg::UNLOCK_KEY
         && !r.sw_reset_pulse) |-> !r.locked)
        else $error("unlock key did not unlock");
    chk_locked_write: assert property (@(posedge clk_sys) disable iff (!arst_n)
        r.wr_valid |-> !($past(r.locked) && is_protected(r.wr_ptr)))
        else $error("protected write passed while locked");
    chk_hs_stop: assert property (@(posedge clk_sys) disable iff (!arst_n)
        stop_c |=> !r.hs_mode)
        else $error("high speed kept after stop");
    chk_timeout_release: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (r.busy && r.tocnt >= 25'(TIMEOUT_LIMIT) && !start_c && !stop_c) |=> (!r.sda_oe && !r.busy))
        else $error("timeout did not release bus");
    chk_block_wrap: assert property (@(posedge clk_sys) disable iff (!arst_n)
        ($past(r.ptr) == twrap_pkg::PTR_BLOCK_LAST && r.ptr != $past(r.ptr) && !r.sw_reset_pulse
         && !$past(r.ptr_phase)) |-> r.ptr == twrap_pkg::PTR_BLOCK_FIRST)
        else $error("block pointer did not wrap");
    chk_swreset_ptr: assert property (@(posedge clk_sys) disable iff (!arst_n)
        r.sw_reset_pulse |=> (r.locked && r.ptr == twrap_pkg::PTR_RESET))
        else $error("software reset incomplete");
    chk_commit_pair: assert property (@(posedge clk_sys) disable iff (!arst_n)
        r.wr_valid |-> !r.low_phase)
        else $error("commit without full pair");
    chk_ack_release: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (r.st == twrap_pkg::TWRAP_RXB && r.bitcnt == 4'd1) |-> !r.sda_oe)
        else $error("ack still driven during data bits");
    chk_hs_nack: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (r.hs_mode && !$past(r.hs_mode)) |-> !r.sda_oe)
        else $error("high speed code was acknowledged");
endmodule
`default_nettype wire

// >>> twrap_top_tb_top.sv
// testbench for the two-wire register access port
`timescale 1ns/1ps
`default_nettype none
module twrap_top_tb_top;
    localparam int TO = 200;
    logic        clk_sys = 1'b0;
    logic        arst_n = 1'b0;
    logic [1:0]  addr_strap = twrap_pkg::STRAP_GND;
    logic [15:0] temp_result [twrap_pkg::NUM_TEMP];
    logic        sda_out, sda_oe, hs_mode, sw_reset_pulse, locked, reg_wr_valid, scl_low, sda_low, a;
    logic [7:0]  reg_wr_ptr, last_ptr;
    logic [15:0] reg_wr_data, last_data, w;
    int          errors = 0, n_checks = 0, n_wr = 0, n_sw = 0;
    wire logic   sda_line = ~(sda_low | (sda_oe & ~sda_out));
    always #5 clk_sys = ~clk_sys;
    twrap_top #(.TIMEOUT_LIMIT(TO)) twrap_top_i (.clk_sys(clk_sys), .arst_n(arst_n), .scl_in(~scl_low),
        .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap(addr_strap),
        .temp_result(temp_result), .hs_mode(hs_mode), .sw_reset_pulse(sw_reset_pulse), .locked(locked),
        .reg_wr_valid(reg_wr_valid), .reg_wr_ptr(reg_wr_ptr), .reg_wr_data(reg_wr_data));
    twrap_bm twrap_bm_i (.clk_sys(clk_sys), .sda_line(sda_line), .scl_low(scl_low), .sda_low(sda_low));
    function automatic logic [15:0] exp_t(input int i);
        return 16'h0a53 ^ (16'h1111 * 16'(i));
    endfunction
    function automatic logic [7:0] ab(input logic rw);
        return {twrap_pkg::ADDR_UPPER, addr_strap, rw};
    endfunction
    initial for (int i = 0; i < twrap_pkg::NUM_TEMP; i++) temp_result[i] = exp_t(i);
    // ****************************************
    // committed words and reset pulses
    // ****************************************
    always @(posedge clk_sys) begin
        if (reg_wr_valid === 1'b1) begin
            n_wr++;
            last_ptr = reg_wr_ptr;
            last_data = reg_wr_data;
        end
        if (sw_reset_pulse === 1'b1) n_sw++;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] p, input logic [15:0] d, input int nb);
        twrap_bm_i.start();
        twrap_bm_i.wr_byte(ab(1'b0), a);
        chk(16'(a), 16'h0001);
        twrap_bm_i.wr_byte(p, a);
        if (nb > 0) twrap_bm_i.wr_byte(d[15:8], a);
        if (nb > 1) twrap_bm_i.wr_byte(d[7:0], a);
        twrap_bm_i.stop();
    endtask
    task automatic rd(input int nb);
        logic [7:0] hi, lo;
        twrap_bm_i.start();
        twrap_bm_i.wr_byte(ab(1'b1), a);
        chk(16'(a), 16'h0001);
        lo = 8'h00;
        twrap_bm_i.rd_byte(nb > 1, hi);
        if (nb > 1) twrap_bm_i.rd_byte(1'b0, lo);
        twrap_bm_i.stop();
        w = {hi, lo};
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset();
        chk({14'h0000, hs_mode, sda_oe}, 16'h0000);
        chk(16'(locked), 16'h0001);
        rd(2);
        chk(w, exp_t(0));
    endtask
    task automatic t_strap();
        for (int s = 0; s < 4; s++) begin
            addr_strap <= 2'(s);
            twrap_bm_i.q(4);
            wr(twrap_pkg::PTR_RESET, 16'h0000, 0);
            twrap_bm_i.start();
            twrap_bm_i.wr_byte({twrap_pkg::ADDR_UPPER, 2'(s + 1), 1'b0}, a);
            chk(16'(a), 16'h0000);
            twrap_bm_i.stop();
        end
        addr_strap <= twrap_pkg::STRAP_GND;
        twrap_bm_i.q(4);
    endtask
    task automatic t_lock();
        int n0;
        n0 = n_wr;
        wr(twrap_pkg::PTR_LIMIT_LAST, 16'h1234, 2);
        chk({a, 7'h00, 8'(n_wr - n0)}, 16'h0000);
        wr(twrap_pkg::PTR_LOCK, twrap_pkg::UNLOCK_KEY, 2);
        chk({last_ptr, 8'(n_wr - n0)}, {twrap_pkg::PTR_LOCK, 8'h01});
        chk(last_data, twrap_pkg::UNLOCK_KEY);
        chk(16'(locked), 16'h0000);
        wr(twrap_pkg::PTR_CONFIG, 16'h5a5a, 1);
        chk(16'(n_wr - n0), 16'h0001);
        wr(twrap_pkg::PTR_CONFIG, 16'hc3e1, 2);
        chk({a, 7'h00, last_ptr}, {8'h80, twrap_pkg::PTR_CONFIG});
        chk(last_data, 16'hc3e1);
        wr(twrap_pkg::PTR_LOCK, twrap_pkg::LOCK_KEY, 2);
        chk(16'(locked), 16'h0001);
        rd(2);
        chk(w, 16'h0001);
    endtask
    task automatic t_single();
        wr(twrap_pkg::PTR_TEMP_LAST, 16'h0000, 0);
        rd(2);
        chk(w, exp_t(8));
        rd(1);
        chk(w, exp_t(8) & 16'hff00);
        rd(2);
        chk(w, exp_t(8));
    endtask
    task automatic t_block();
        logic [7:0] hi, lo;
        wr(twrap_pkg::PTR_BLOCK_FIRST, 16'h0000, 0);
        twrap_bm_i.start();
        twrap_bm_i.wr_byte(ab(1'b1), a);
        for (int i = 0; i < 10; i++) begin
            twrap_bm_i.rd_byte(1'b1, hi);
            twrap_bm_i.rd_byte(i < 9, lo);
            chk({hi, lo}, exp_t(i % 9));
        end
        twrap_bm_i.stop();
        wr(8'h86, 16'h0000, 0);
        rd(2);
        chk(w, exp_t(6));
        rd(2);
        chk(w, exp_t(7));
    endtask
    task automatic t_hs();
        for (int x = 0; x < 8; x++) begin
            twrap_bm_i.start();
            twrap_bm_i.wr_byte({twrap_pkg::HS_CODE_TOP, 3'(x)}, a);
            chk({15'h0000, a}, 16'h0000);
            chk(16'(hs_mode), 16'h0001);
            twrap_bm_i.start();
            twrap_bm_i.wr_byte(ab(1'b0), a);
            twrap_bm_i.wr_byte(twrap_pkg::PTR_RESET, a);
            chk({14'h0000, a, hs_mode}, 16'h0003);
            twrap_bm_i.stop();
            twrap_bm_i.q(6);
            chk(16'(hs_mode), 16'h0000);
        end
    endtask
    task automatic t_swreset();
        wr(twrap_pkg::PTR_LOCK, twrap_pkg::UNLOCK_KEY, 2);
        wr(twrap_pkg::PTR_SW_RESET, 16'h7fff, 2);
        chk({7'h00, locked, 8'(n_sw)}, 16'h0000);
        wr(twrap_pkg::PTR_SW_RESET, 16'h8000, 2);
        chk({7'h00, locked, 8'(n_sw)}, 16'h0101);
        rd(2);
        chk(w, exp_t(0));
    endtask
    task automatic t_timeout();
        twrap_bm_i.start();
        twrap_bm_i.wr_byte(ab(1'b1), a);
        twrap_bm_i.q(12);
        chk(16'(sda_oe), 16'h0001);
        twrap_bm_i.q(TO + 20);
        chk(16'(sda_oe), 16'h0000);
        twrap_bm_i.stop();
        rd(2);
        chk(w, exp_t(0));
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk_sys);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        t_reset();
        t_strap();
        t_lock();
        t_single();
        t_block();
        t_hs();
        t_swreset();
        t_timeout();
        give_verdict();
    end
    initial begin
        repeat (60000) @(posedge clk_sys);
        errors++;
        give_verdict();
    end
endmodule
`default_nettype wire
